/* File: rtl/trig_seq_pkg.sv */
// Constants, register map and types for the measurement trigger sequencer.
// Assumes a 100 MHz pclk; all delays are kept in microseconds.
package trig_seq_pkg;

    // ========================================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam longint DELAY_MAX_S = 3600;
    localparam logic [31:0] DELAY_MAX_US = 32'(DELAY_MAX_S * 64'd1000000);
    localparam logic [31:0] DELAY_RST_US = 32'h0000_0000;
    localparam logic [31:0] DLY_DC_HI_US = 32'(1500);
    localparam logic [31:0] DLY_DC_LO_US = 32'(1000);
    localparam logic [31:0] DLY_RES_1M_HI_US = 32'(15000);
    localparam logic [31:0] DLY_RES_1M_LO_US = 32'(10000);
    localparam logic [31:0] DLY_RES_10M_US = 32'(100000);
    localparam logic [31:0] DLY_AC3_TRG_US = 32'(7000000);
    localparam logic [31:0] DLY_AC20_TRG_US = 32'(1000000);
    localparam logic [31:0] DLY_AC200_TRG_US = 32'(600000);
    localparam logic [31:0] DLY_AC3_AUTO_US = 32'(1500000);
    localparam logic [31:0] DLY_AC20_AUTO_US = 32'(200000);
    localparam logic [31:0] DLY_AC200_AUTO_US = 32'(100000);
    localparam logic [31:0] DLY_FREQ_TRG_US = 32'(1000000);
    localparam logic [31:0] DLY_FREQ_AUTO_US = 32'(0);

    // ========================================================================
    // Counts and widths
    localparam int READ_W = 24;
    localparam int HOLD_STABLE_N = 3;
    localparam logic [15:0] SAMPLES_MAX = 16'hC350;
    localparam logic [15:0] SAMPLES_RST = 16'h0001;
    localparam logic [15:0] TRIGS_RST = 16'h0001;
    localparam logic [23:0] BAND_RST = 24'h000000;

    // ========================================================================
    // Register offsets
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_SAMPLES = 12'h004;
    localparam logic [11:0] REG_TRIGS = 12'h008;
    localparam logic [11:0] REG_DELAY = 12'h00C;
    localparam logic [11:0] REG_MEAS_CFG = 12'h010;
    localparam logic [11:0] REG_BAND = 12'h014;
    localparam logic [11:0] REG_CMD = 12'h018;
    localparam logic [11:0] REG_STATUS = 12'h01C;
    localparam logic [11:0] REG_HELD = 12'h020;
    localparam logic [11:0] REG_ACT_DELAY = 12'h024;

    // ========================================================================
    // Field positions
    localparam int CTRL_AUTO_DLY = 0;
    localparam int CTRL_HOLD = 1;
    localparam int CTRL_SRC_LO = 2;
    localparam int CTRL_FRONT_AUTO = 4;
    localparam logic CTRL_AUTO_DLY_RST = 1'b1;
    localparam int CMD_ARM = 0;
    localparam int CMD_SWTRIG = 1;
    localparam int CMD_ABORT = 2;
    localparam int CFG_FUNC_LO = 0;
    localparam int CFG_RANGE_LO = 2;
    localparam int CFG_PLC = 4;
    localparam int CFG_FILT_LO = 5;

    // ========================================================================
    // Types
    typedef enum logic [1:0] {
        SRC_IMM = 2'h0, SRC_BUS = 2'h1, SRC_EXT = 2'h2, SRC_SINGLE = 2'h3
    } trig_src_t;
    typedef enum logic [1:0] {
        FN_DC = 2'h0, FN_RES = 2'h1, FN_AC = 2'h2, FN_FREQ = 2'h3
    } func_t;
    typedef enum logic [1:0] {
        S_IDLE = 2'b00, S_WAIT = 2'b01, S_SETTLE = 2'b11, S_MEASURE = 2'b10
    } seq_state_t;

endpackage

/* File: rtl/pin_sync.sv */
// Two flip-flop synchroniser for one asynchronous pin.
// Assumes the pin level is held for at least two pclk periods.
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic meta;
        logic sync;
    } sync_state_t;
    sync_state_t st_q, st_d;

    always_comb begin
        st_d.meta = pin;
        st_d.sync = st_q.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.sync;
endmodule
`default_nettype wire

/* File: rtl/settle_timer.sv */
// Settling delay timer counting whole microseconds from a tick divider.
// Assumes start is a one-cycle pulse; done is low from the cycle after start.
`timescale 1ns/10ps
`default_nettype none
module settle_timer
    import trig_seq_pkg::*;
#(
    parameter logic [15:0] TICK_LEN = 16'(TICK_CYCLES)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [31:0] load_us,
    output logic done
);
    typedef struct packed {
        logic busy;
        logic [31:0] cnt;
        logic [15:0] div;
    } tmr_state_t;
    tmr_state_t st_q, st_d;

    always_comb begin
        st_d = st_q;
        if (start) begin
            st_d.busy = 1'b1;
            st_d.cnt = load_us;
            st_d.div = 16'h0000;
        end else if (st_q.busy) begin
            if (st_q.cnt == 32'h0000_0000) begin
                st_d.busy = 1'b0;
            end else if (st_q.div == TICK_LEN - 16'h0001) begin
                st_d.div = 16'h0000;
                st_d.cnt = st_q.cnt - 32'h0000_0001;
            end else begin
                st_d.div = st_q.div + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign done = !st_q.busy;
endmodule
`default_nettype wire

/* File: rtl/measurement_trigger_sequencer.sv */
// Trigger sequencer: trigger acceptance, settling delay, sample bursts and reading hold.
// Assumes an APB master on pclk and a converter that answers meas_start with meas_done.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - One reading per trigger by default, programmable up to 50000 readings.
// - The readings-per-trigger value is volatile and resets to one.
// - One trigger is accepted before idle by default, or a remotely set count.
// - With hold on, three successive readings within the band freeze the display and beep.
// - A programmed delay from 0 to 3600 s is accepted and is volatile.
// - Automatic delay is the default, a programmed delay is used when given, auto can toggle.
// - Automatic delay is looked up from function, range, integration time and filter.
// - DC and resistance automatic delays follow integration time and range.
// - AC automatic delays follow the filter and whether front-panel auto trigger is on.
// - Frequency and period use 1.0 s when triggered, zero with front-panel auto trigger.
// - Immediate mode triggers itself as soon as the wait-for-trigger state is entered.
// - Each external trigger pulse in the wait-for-trigger state starts one burst of the programmed readings; other pulses are ignored.
module measurement_trigger_sequencer
    import trig_seq_pkg::*;
#(
    parameter logic [15:0] TICK_LEN = 16'(TICK_CYCLES)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_trig_pin,
    input wire logic single_key_pin,
    output logic meas_start,
    input wire logic meas_done,
    input wire logic [READ_W-1:0] meas_data,
    output logic [READ_W-1:0] display_value,
    output logic hold_frozen,
    output logic beep,
    output logic trig_ready
);
    // ========================================================================
    // State
    typedef struct packed {
        seq_state_t state;
        logic [15:0] samples;
        logic [15:0] trigs;
        logic [31:0] delay;
        logic auto_dly;
        logic hold_en;
        trig_src_t src;
        logic front_auto;
        func_t func;
        logic [1:0] range;
        logic plc_ge1;
        logic [1:0] filt;
        logic [23:0] band;
        logic [15:0] burst_left;
        logic [15:0] trig_left;
        logic [READ_W-1:0] base;
        logic [1:0] stable_cnt;
        logic frozen;
        logic [READ_W-1:0] disp;
        logic beep;
        logic start;
        logic ext_prev;
        logic key_prev;
        logic [31:0] rdata;
        logic err;
    } seq_reg_t;
    seq_reg_t st_q, st_d;

    logic ext_lvl, key_lvl, tmr_done, tmr_start, ext_edge, key_edge;
    logic wr_en, rd_setup, sw_trig, arm, abort, accept, last_sample;
    logic [31:0] sel_delay;
    logic signed [READ_W:0] diff;
    logic [READ_W:0] abs_diff;

    pin_sync ext_sync (.pclk(pclk), .presetn(presetn), .pin(ext_trig_pin), .level(ext_lvl));
    pin_sync key_sync (.pclk(pclk), .presetn(presetn), .pin(single_key_pin), .level(key_lvl));

    settle_timer #(.TICK_LEN(TICK_LEN)) timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(tmr_start),
        .load_us(sel_delay),
        .done(tmr_done)
    );

    // ========================================================================
    // Automatic delay lookup
    function automatic logic [31:0] auto_delay(input func_t fn, input logic [1:0] rng,
                                              input logic power_line_cycles, input logic [1:0] flt,
                                              input logic fp_auto);
        logic [31:0] d;
        d = DLY_DC_LO_US;
        case (fn)
            FN_DC: d = power_line_cycles ? DLY_DC_HI_US : DLY_DC_LO_US;
            FN_RES: begin
                if (rng == 2'h0) begin
                    d = power_line_cycles ? DLY_DC_HI_US : DLY_DC_LO_US;
                end else if (rng == 2'h1) begin
                    d = power_line_cycles ? DLY_RES_1M_HI_US : DLY_RES_1M_LO_US;
                end else begin
                    d = DLY_RES_10M_US;
                end
            end
            FN_AC: begin
                case (flt)
                    2'h0: d = fp_auto ? DLY_AC3_AUTO_US : DLY_AC3_TRG_US;
                    2'h1: d = fp_auto ? DLY_AC20_AUTO_US : DLY_AC20_TRG_US;
                    default: d = fp_auto ? DLY_AC200_AUTO_US : DLY_AC200_TRG_US;
                endcase
            end
            FN_FREQ: d = fp_auto ? DLY_FREQ_AUTO_US : DLY_FREQ_TRG_US;
            default: d = DLY_DC_LO_US;
        endcase
        return d;
    endfunction

    // A programmed delay replaces the table until auto is switched back on.
    assign sel_delay = st_q.auto_dly ? auto_delay(st_q.func, st_q.range, st_q.plc_ge1,
                                                  st_q.filt, st_q.front_auto)
                                     : st_q.delay;

    // ========================================================================
    // Bus decode and events
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign sw_trig = wr_en && paddr == REG_CMD && pwdata[CMD_SWTRIG];
    assign arm = wr_en && paddr == REG_CMD && pwdata[CMD_ARM];
    assign abort = wr_en && paddr == REG_CMD && pwdata[CMD_ABORT];
    assign ext_edge = ext_lvl && !st_q.ext_prev;
    assign key_edge = key_lvl && !st_q.key_prev;
    assign last_sample = st_q.burst_left == 16'h0001;
    assign diff = $signed({meas_data[READ_W-1], meas_data})
                - $signed({st_q.base[READ_W-1], st_q.base});
    assign abs_diff = diff[READ_W] ? (READ_W+1)'(-diff) : diff;

    always_comb begin
        accept = 1'b0;
        if (st_q.front_auto) begin
            accept = 1'b1;
        end else begin
            case (st_q.src)
                SRC_IMM: accept = 1'b1;
                SRC_BUS: accept = sw_trig;
                SRC_EXT: accept = ext_edge;
                SRC_SINGLE: accept = key_edge;
                default: accept = 1'b0;
            endcase
        end
    end

    assign tmr_start = st_q.state == S_WAIT && accept && !abort;

    // ========================================================================
    // Next state
    always_comb begin
        st_d = st_q;
        st_d.ext_prev = ext_lvl;
        st_d.key_prev = key_lvl;
        st_d.beep = 1'b0;
        st_d.start = 1'b0;
        if (wr_en) begin
            case (paddr)
                REG_CTRL: begin
                    st_d.auto_dly = pwdata[CTRL_AUTO_DLY];
                    st_d.hold_en = pwdata[CTRL_HOLD];
                    st_d.src = trig_src_t'(pwdata[CTRL_SRC_LO +: 2]);
                    st_d.front_auto = pwdata[CTRL_FRONT_AUTO];
                end
                REG_SAMPLES: begin
                    if (pwdata[31:16] != 16'h0000 || pwdata[15:0] > SAMPLES_MAX) begin
                        st_d.samples = SAMPLES_MAX;
                    end else if (pwdata[15:0] == 16'h0000) begin
                        st_d.samples = SAMPLES_RST;
                    end else begin
                        st_d.samples = pwdata[15:0];
                    end
                end
                REG_TRIGS: st_d.trigs = (pwdata[15:0] == 16'h0000) ? TRIGS_RST : pwdata[15:0];
                REG_DELAY: begin
                    st_d.delay = (pwdata > DELAY_MAX_US) ? DELAY_MAX_US : pwdata;
                    st_d.auto_dly = 1'b0;
                end
                REG_MEAS_CFG: begin
                    st_d.func = func_t'(pwdata[CFG_FUNC_LO +: 2]);
                    st_d.range = pwdata[CFG_RANGE_LO +: 2];
                    st_d.plc_ge1 = pwdata[CFG_PLC];
                    st_d.filt = pwdata[CFG_FILT_LO +: 2];
                end
                REG_BAND: st_d.band = pwdata[23:0];
                default: ;
            endcase
        end
        if (rd_setup) begin
            st_d.err = 1'b0;
            case (paddr)
                REG_CTRL: st_d.rdata = {27'h0, st_q.front_auto, st_q.src, st_q.hold_en,
                                        st_q.auto_dly};
                REG_SAMPLES: st_d.rdata = {16'h0000, st_q.samples};
                REG_TRIGS: st_d.rdata = {16'h0000, st_q.trigs};
                REG_DELAY: st_d.rdata = st_q.delay;
                REG_MEAS_CFG: st_d.rdata = {25'h0, st_q.filt, st_q.plc_ge1, st_q.range,
                                            st_q.func};
                REG_BAND: st_d.rdata = {8'h00, st_q.band};
                REG_CMD: st_d.rdata = 32'h0000_0000;
                REG_STATUS: st_d.rdata = {st_q.trig_left, st_q.burst_left[11:0],
                                          st_q.frozen, st_q.state == S_WAIT, st_q.state};
                REG_HELD: st_d.rdata = {8'h00, st_q.disp};
                REG_ACT_DELAY: st_d.rdata = sel_delay;
                default: begin
                    st_d.rdata = 32'h0000_0000;
                    st_d.err = 1'b1;
                end
            endcase
        end
        // Leaving hold releases the frozen reading and restarts the stability search.
        if (!st_q.hold_en) begin
            st_d.frozen = 1'b0;
            st_d.stable_cnt = 2'h0;
        end
        case (st_q.state)
            S_IDLE: begin
                if ((arm || st_q.front_auto) && !abort) begin
                    st_d.state = S_WAIT;
                    st_d.trig_left = st_q.trigs;
                end
            end
            S_WAIT: begin
                if (abort) begin
                    st_d.state = S_IDLE;
                end else if (accept) begin
                    st_d.state = S_SETTLE;
                    st_d.burst_left = st_q.samples;
                end
            end
            S_SETTLE: begin
                if (abort) begin
                    st_d.state = S_IDLE;
                end else if (tmr_done) begin
                    st_d.state = S_MEASURE;
                    st_d.start = 1'b1;
                end
            end
            S_MEASURE: begin
                if (abort) begin
                    st_d.state = S_IDLE;
                end else if (meas_done) begin
                    if (!last_sample) begin
                        st_d.burst_left = st_q.burst_left - 16'h0001;
                        st_d.start = 1'b1;
                    end else if (st_q.front_auto || st_q.trig_left > 16'h0001) begin
                        st_d.burst_left = 16'h0000;
                        st_d.trig_left = st_q.front_auto ? st_q.trig_left
                                                         : st_q.trig_left - 16'h0001;
                        st_d.state = S_WAIT;
                    end else begin
                        st_d.burst_left = 16'h0000;
                        st_d.trig_left = 16'h0000;
                        st_d.state = S_IDLE;
                    end
                end
            end
            default: st_d.state = S_IDLE;
        endcase
        if (meas_done && st_q.state == S_MEASURE && !st_q.frozen) begin
            st_d.disp = meas_data;
            if (st_q.hold_en) begin
                if (st_q.stable_cnt != 2'h0 && abs_diff <= {1'b0, st_q.band}) begin
                    st_d.stable_cnt = st_q.stable_cnt + 2'h1;
                    if (st_q.stable_cnt == 2'(HOLD_STABLE_N - 1)) begin
                        st_d.frozen = 1'b1;
                        st_d.beep = 1'b1;
                    end
                end else begin
                    st_d.base = meas_data;
                    st_d.stable_cnt = 2'h1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
            st_q.samples <= SAMPLES_RST;
            st_q.trigs <= TRIGS_RST;
            st_q.delay <= DELAY_RST_US;
            st_q.auto_dly <= CTRL_AUTO_DLY_RST;
            st_q.band <= BAND_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.rdata;
    assign pslverr = psel && penable && st_q.err;
    assign pready = 1'b1;
    assign meas_start = st_q.start;
    assign display_value = st_q.disp;
    assign hold_frozen = st_q.frozen;
    assign beep = st_q.beep;
    assign trig_ready = st_q.state == S_WAIT;

    // ========================================================================
    // Checks
    a_samples_reset: assert property (@(posedge pclk) $rose(presetn) |-> st_q.samples == 16'h0001)
        else $error("samples per trigger not one after reset");
    a_samples_range: assert property (@(posedge pclk) disable iff (!presetn)
        st_q.samples >= 16'h0001 && st_q.samples <= SAMPLES_MAX)
        else $error("samples per trigger out of range");
    a_trig_count_idle: assert property (@(posedge pclk) disable iff (!presetn)
        st_q.state == S_MEASURE && meas_done && last_sample && !abort && !st_q.front_auto
        && st_q.trig_left == 16'h0001 |=> st_q.state == S_IDLE)
        else $error("sequencer did not go idle after last trigger");
    a_hold_beep: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(hold_frozen) |-> beep && $past(st_q.stable_cnt) == 2'h2)
        else $error("hold froze without beep or three stable readings");
    a_delay_max: assert property (@(posedge pclk) disable iff (!presetn)
        st_q.delay <= DELAY_MAX_US)
        else $error("programmed delay above limit");
    a_auto_default: assert property (@(posedge pclk) $rose(presetn) |-> st_q.auto_dly)
        else $error("automatic delay not default");
    a_dc_table: assert property (@(posedge pclk) disable iff (!presetn)
        st_q.auto_dly && st_q.func == FN_DC |-> sel_delay == (st_q.plc_ge1 ? 32'(1500) : 32'(1000)))
        else $error("wrong automatic DC delay");
    a_ac_table: assert property (@(posedge pclk) disable iff (!presetn)
        st_q.auto_dly && st_q.func == FN_AC && st_q.filt == 2'h0
        |-> sel_delay == (st_q.front_auto ? 32'(1500000) : 32'(7000000)))
        else $error("wrong automatic AC delay");
    a_freq_table: assert property (@(posedge pclk) disable iff (!presetn)
        st_q.auto_dly && st_q.func == FN_FREQ |-> sel_delay == (st_q.front_auto ? 32'(0)
        : 32'(1000000)))
        else $error("wrong automatic frequency delay");
    a_immediate_trig: assert property (@(posedge pclk) disable iff (!presetn)
        st_q.state == S_WAIT && st_q.src == SRC_IMM && !abort |=> st_q.state == S_SETTLE)
        else $error("immediate trigger not taken");
    a_ext_burst: assert property (@(posedge pclk) disable iff (!presetn)
        st_q.state == S_WAIT && st_q.src == SRC_EXT && !st_q.front_auto && ext_edge && !abort
        |=> st_q.state == S_SETTLE && st_q.burst_left == st_q.samples)
        else $error("external pulse did not start a burst");
    a_delay_first: assert property (@(posedge pclk) disable iff (!presetn)
        st_q.state == S_WAIT && accept && !abort |=> !meas_start ##1 !meas_start)
        else $error("reading started before settling delay");
endmodule
`default_nettype wire

/* File: sim/conv_model.sv */
// Behavioural converter and trigger pins on the far side of the sequencer.
// Assumes one pclk domain and a one-cycle meas_start pulse.
`timescale 1ns/10ps
`default_nettype none
module conv_model (
    input wire logic pclk,
    input wire logic meas_start,
    input wire logic [23:0] val,
    input wire logic ext_req,
    input wire logic key_req,
    output logic meas_done,
    output logic [23:0] meas_data,
    output logic ext_trig_pin,
    output logic single_key_pin
);
    // ========================================
    // Between done pulses the data toggles, so a sample taken one cycle late never matches.
    logic pend = 1'b0;
    logic [1:0] wait_q = 2'h0;
    integer seed = 32'h755DA485;
    initial begin
        {meas_done, ext_trig_pin, single_key_pin} = 3'h0;
        meas_data = 24'h0;
    end
    always @(posedge pclk) begin
        ext_trig_pin <= ext_req;
        single_key_pin <= key_req;
        meas_done <= 1'b0;
        meas_data <= ~meas_data;
        if (pend && wait_q == 2'h0) begin
            meas_done <= 1'b1;
            meas_data <= val;
            pend <= 1'b0;
        end else if (pend) begin
            wait_q <= wait_q - 2'h1;
        end
        if (meas_start) begin
            pend <= 1'b1;
            wait_q <= 2'($random(seed));
        end
    end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the trigger sequencer, register access over APB.
// Assumes TICK_LEN of one, so delays count cycles.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import trig_seq_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic pready, pslverr, meas_start, meas_done, hold_frozen, beep, trig_ready, e;
    logic ext_req = 1'b0;
    logic key_req = 1'b0;
    logic ext_trig_pin, single_key_pin;
    logic [23:0] val = 24'h0;
    logic [23:0] meas_data, display_value;
    integer seed = 32'h755DA485;
    integer errors = 0, checks_done = 0, nst = 0, nbeep = 0, cyc = 0, t0 = 0, t1 = 0;
    always #5 pclk = ~pclk;
    measurement_trigger_sequencer #(.TICK_LEN(16'h0001)) measurement_trigger_sequencer_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_trig_pin(ext_trig_pin), .single_key_pin(single_key_pin), .meas_start(meas_start),
        .meas_done(meas_done), .meas_data(meas_data), .display_value(display_value),
        .hold_frozen(hold_frozen), .beep(beep), .trig_ready(trig_ready));
    conv_model conv_model_inst (.pclk(pclk), .meas_start(meas_start), .val(val),
        .ext_req(ext_req), .key_req(key_req), .meas_done(meas_done), .meas_data(meas_data),
        .ext_trig_pin(ext_trig_pin), .single_key_pin(single_key_pin));
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (meas_start === 1'b1) begin
            nst <= nst + 1;
            if (nst == 0) t1 <= cyc;
        end
        if (beep === 1'b1) nbeep <= nbeep + 1;
    end
    // ========================================
    // Shared tasks.
    task give_verdict;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] x);
        checks_done++;
        if (got !== x) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, x);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk({31'h0, pready}, 32'h1);
        if (n >= 50) give_verdict;
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r & m, x);
    endtask
    task wait_n(input integer k);
        integer n;
        for (n = 0; nst < k && n < 3000; n++) @(posedge pclk);
        chk({31'h0, nst >= k}, 32'h1);
        if (nst < k) give_verdict;
        repeat (12) @(posedge pclk);
    endtask
    function logic [31:0] auto_dly(input logic [6:0] c, input logic fa);
        logic [1:0] f;
        f = c[6:5];
        case (c[1:0])
            2'h0: return c[4] ? 32'h5DC : 32'h3E8;
            2'h1: return c[3:2] == 2'h0 ? (c[4] ? 32'h5DC : 32'h3E8) :
                c[3:2] == 2'h1 ? (c[4] ? 32'h3A98 : 32'h2710) : 32'h186A0;
            2'h2: return fa ? (f == 0 ? 32'h16E360 : f == 1 ? 32'h30D40 : 32'h186A0) :
                (f == 0 ? 32'h6ACFC0 : f == 1 ? 32'hF4240 : 32'h927C0);
            default: return fa ? 32'h0 : 32'hF4240;
        endcase
    endfunction
    // ========================================
    // Main sequence.
    initial begin
        integer i, j;
        logic [6:0] c;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(REG_CTRL, 32'h1F, 32'h1);
        rd(REG_SAMPLES, 32'hFFFF, 32'h1);
        rd(REG_TRIGS, 32'hFFFF, 32'h1);
        rd(REG_DELAY, 32'hFFFFFFFF, 32'h0);
        rd(12'h0FC, 32'hFFFFFFFF, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, REG_SAMPLES, 32'hEA60);
        rd(REG_SAMPLES, 32'hFFFF, 32'hC350);
        presetn <= 1'b0;
        @(posedge pclk) presetn <= 1'b1;
        rd(REG_SAMPLES, 32'hFFFF, 32'h1);
        for (i = 0; i < 24; i++) begin
            c = 7'($random(seed));
            apb(1'b1, REG_CTRL, {27'h0, i[0], 4'h1});
            apb(1'b1, REG_MEAS_CFG, {25'h0, c});
            rd(REG_ACT_DELAY, 32'hFFFFFFFF, auto_dly(c, i[0]));
            apb(1'b1, REG_CTRL, 32'h1);
            apb(1'b1, REG_CMD, 32'h4);
        end
        apb(1'b1, REG_DELAY, 32'hFFFFFFFF);
        rd(REG_DELAY, 32'hFFFFFFFF, 32'hD693A400);
        rd(REG_CTRL, 32'h1, 32'h0);
        apb(1'b1, REG_DELAY, 32'h8);
        rd(REG_ACT_DELAY, 32'hFFFFFFFF, 32'h8);
        apb(1'b1, REG_SAMPLES, 32'h3);
        apb(1'b1, REG_TRIGS, 32'h2);
        apb(1'b1, REG_CTRL, 32'h4);
        apb(1'b1, REG_CMD, 32'h1);
        nst = 0;
        apb(1'b1, REG_CMD, 32'h2);
        t0 = cyc;
        wait_n(3);
        chk({31'h0, t1 - t0 >= 8 && t1 - t0 <= 12}, 32'h1);
        chk({31'h0, trig_ready}, 32'h1);
        apb(1'b1, REG_CMD, 32'h2);
        wait_n(6);
        rd(REG_STATUS, 32'h3, 32'h0);
        chk(32'(nst), 32'h6);
        apb(1'b1, REG_DELAY, 32'h0);
        apb(1'b1, REG_SAMPLES, 32'h0);
        for (i = 2; i < 4; i++) begin
            apb(1'b1, REG_CTRL, 32'(i) << 2);
            apb(1'b1, REG_CMD, 32'h1);
            nst = 0;
            for (j = 0; j < 3; j++) begin
                ext_req <= (i == 2);
                key_req <= (i == 3);
                repeat (4) @(posedge pclk);
                {ext_req, key_req} <= 2'h0;
                wait_n(j < 2 ? j + 1 : 2);
            end
            chk(32'(nst), 32'h2);
        end
        apb(1'b1, REG_TRIGS, 32'h0);
        apb(1'b1, REG_CTRL, 32'h0);
        nst = 0;
        apb(1'b1, REG_CMD, 32'h1);
        wait_n(1);
        rd(REG_STATUS, 32'h3, 32'h0);
        apb(1'b1, REG_BAND, 32'h4);
        apb(1'b1, REG_SAMPLES, 32'h3);
        apb(1'b1, REG_CTRL, 32'h6);
        val <= 24'h64;
        nst = 0;
        apb(1'b1, REG_CMD, 32'h1);
        apb(1'b1, REG_CMD, 32'h2);
        wait_n(3);
        chk({31'h0, hold_frozen}, 32'h1);
        chk({8'h0, display_value}, 32'h64);
        chk(32'(nbeep), 32'h1);
        give_verdict;
    end
    initial begin
        repeat (90000) @(posedge pclk);
        errors++;
        give_verdict;
    end
endmodule
`default_nettype wire
